// File: bhd_regs.svh
// Constants for the hall commutation decoder
`ifndef BHD_REGS_SVH
`define BHD_REGS_SVH

`define BHD_LVL_W 8
`define BHD_SPEED_OFF_THRESHOLD 8'h20
`define BHD_UV_DETECT 8'h30
`define BHD_UV_HYSTERESIS 8'h10
`define BHD_CARRIER_MAX 8'hff
`define BHD_REFRESH_FRACTION 5
`define BHD_REFRESH_STEPS 8'h66
`define BHD_HALL_RESET 3'h0

`endif

// File: bhd_pkg.sv
// Types, decode and three-pulse functions for the hall commutation decoder
`default_nettype none

package bhd_pkg;

	typedef logic [2:0] bhd_hall_t;

	typedef enum logic [1:0] {
		BHD_REF_IDLE = 2'b00,
		BHD_REF_ACTIVE = 2'b01,
		BHD_REF_DONE = 2'b10
	} bhd_refresh_t;

	// Hall code {a,b,c} to {high[a,b,c], low[a,b,c]}
	function automatic logic [5:0] bhd_decode(input bhd_hall_t code);
		logic [5:0] sw;
		sw = 6'h00;
		unique case (code)
			3'b101: sw = {3'b010, 3'b100};
			3'b100: sw = {3'b001, 3'b100};
			3'b110: sw = {3'b001, 3'b010};
			3'b010: sw = {3'b100, 3'b010};
			3'b011: sw = {3'b100, 3'b001};
			3'b001: sw = {3'b010, 3'b001};
			3'b000: sw = 6'h00;
			3'b111: sw = 6'h00;
		endcase
		return sw;
	endfunction

	// Three-pulse revolution code
	function automatic logic bhd_three_pulse(input bhd_hall_t code);
		return (code == 3'b101) || (code == 3'b110) || (code == 3'b011);
	endfunction

endpackage

`default_nettype wire

// File: bhd_sync.sv
// Two flip-flop synchroniser for pin inputs
`default_nettype none

module bhd_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule

`default_nettype wire

// File: bhd_carrier.sv
// Triangular PWM carrier with rate divider
`include "bhd_regs.svh"
`default_nettype none

module bhd_carrier
	import bhd_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Rate from external parts
	input wire logic [7:0] rate_div,
	// Carrier level
	output logic [7:0] carrier
);

	logic [7:0] div_cnt;
	logic [7:0] div_last;
	logic step;
	logic falling;

	assign div_last = (rate_div == 8'h00) ? 8'h00 : rate_div - 8'h01;
	assign step = (div_cnt >= div_last);

	////////////////////////////////////////////////////////////////////////
	// Divider enable

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			div_cnt <= 8'h00;
		end else if (step) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Triangle up and down

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			carrier <= 8'h00;
			falling <= 1'b0;
		end else if (step) begin
			if (!falling) begin
				if (carrier == `BHD_CARRIER_MAX - 8'h01) begin
					falling <= 1'b1;
				end
				carrier <= carrier + 8'h01;
			end else begin
				if (carrier == 8'h01) begin
					falling <= 1'b0;
				end
				carrier <= carrier - 8'h01;
			end
		end
	end

endmodule

`default_nettype wire

// File: bhd_commutation.sv
// Hall commutation, PWM and revolution pulse logic of a BLDC driver
`include "bhd_regs.svh"
`default_nettype none

module bhd_commutation
	import bhd_pkg::*;
#(
	parameter int LVL_W = `BHD_LVL_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Hall comparator terminals
	input wire logic [LVL_W-1:0] hall_a_pos,
	input wire logic [LVL_W-1:0] hall_a_neg,
	input wire logic [LVL_W-1:0] hall_b_pos,
	input wire logic [LVL_W-1:0] hall_b_neg,
	input wire logic [LVL_W-1:0] hall_c_pos,
	input wire logic [LVL_W-1:0] hall_c_neg,
	// Revolution pulse control
	input wire logic pulse_count_select,
	input wire logic pulse_count_select_open,
	// Speed reference and carrier parts
	input wire logic [7:0] speed_reference,
	input wire logic [3:0] carrier_capacitor_pin,
	input wire logic [3:0] carrier_resistor_pin,
	// High-side supply levels
	input wire logic [LVL_W-1:0] hs_supply_a,
	input wire logic [LVL_W-1:0] hs_supply_b,
	input wire logic [LVL_W-1:0] hs_supply_c,
	// Switch commands
	output logic high_side_a,
	output logic high_side_b,
	output logic high_side_c,
	output logic low_side_a,
	output logic low_side_b,
	output logic low_side_c,
	// Revolution pulse
	output logic revolution_pulse_out
);

	localparam int SW = 9 * LVL_W + 18;

	logic [SW-1:0] pins_raw;
	logic [SW-1:0] pins_s;
	logic [LVL_W-1:0] a_pos_s, a_neg_s, b_pos_s, b_neg_s, c_pos_s, c_neg_s;
	logic [LVL_W-1:0] sup_s [3];
	logic sel_s, open_s;
	logic [7:0] speed_s;
	logic [3:0] cap_s, res_s;
	logic [7:0] rate_div;
	logic [7:0] carrier;
	logic [15:0] refresh_len;
	logic [7:0] div_eff;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	assign pins_raw = {hall_a_pos, hall_a_neg, hall_b_pos, hall_b_neg,
		hall_c_pos, hall_c_neg, hs_supply_a, hs_supply_b, hs_supply_c,
		pulse_count_select, pulse_count_select_open, speed_reference,
		carrier_capacitor_pin, carrier_resistor_pin};

	bhd_sync #(
		.W(SW)
	) u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.d(pins_raw),
		.q(pins_s)
	);

	assign {a_pos_s, a_neg_s, b_pos_s, b_neg_s, c_pos_s, c_neg_s,
		sup_s[2], sup_s[1], sup_s[0], sel_s, open_s, speed_s,
		cap_s, res_s} = pins_s;

	////////////////////////////////////////////////////////////////////////
	// Carrier

	assign rate_div = {4'h0, cap_s} * {4'h0, res_s};
	// A zero rate steps every clock, so the refresh scales as for one
	assign div_eff = (rate_div == 8'h00) ? 8'h01 : rate_div;
	assign refresh_len = {8'h00, `BHD_REFRESH_STEPS} * {8'h00, div_eff};

	bhd_carrier u_carrier (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.rate_div(rate_div),
		.carrier(carrier)
	);

	////////////////////////////////////////////////////////////////////////
	// Hall decode and PWM compare

	bhd_hall_t hall_code;
	bhd_hall_t hall_q;
	logic [5:0] cmd;
	logic [2:0] hs_cmd, ls_cmd;
	logic next_pwm, pwm_q;
	logic run, run_q;
	logic turn_on, turn_q;
	logic sel_eff, sel_q;

	assign hall_code = {a_pos_s > a_neg_s, b_pos_s > b_neg_s,
		c_pos_s > c_neg_s};
	assign cmd = bhd_decode(hall_code);
	assign hs_cmd = cmd[5:3];
	assign ls_cmd = cmd[2:0];
	assign next_pwm = speed_s > carrier;
	assign run = speed_s >= `BHD_SPEED_OFF_THRESHOLD;
	assign turn_on = (hall_code != hall_q) || (next_pwm != pwm_q);
	assign sel_eff = sel_s || open_s;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			hall_q <= `BHD_HALL_RESET;
			pwm_q <= 1'b0;
			run_q <= 1'b0;
			turn_q <= 1'b0;
			sel_q <= 1'b1;
		end else begin
			hall_q <= hall_code;
			pwm_q <= next_pwm;
			run_q <= run;
			turn_q <= turn_on;
			sel_q <= sel_eff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bootstrap refresh timing

	bhd_refresh_t ref_state;
	logic [15:0] ref_cnt;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ref_state <= BHD_REF_IDLE;
			ref_cnt <= 16'h0000;
		end else if (next_pwm || !run) begin
			ref_state <= BHD_REF_IDLE;
			ref_cnt <= 16'h0000;
		end else begin
			unique case (ref_state)
				BHD_REF_IDLE: begin
					if (pwm_q) begin
						ref_state <= BHD_REF_ACTIVE;
						ref_cnt <= 16'h0001;
					end
				end
				BHD_REF_ACTIVE: begin
					if (ref_cnt >= refresh_len) begin
						ref_state <= BHD_REF_DONE;
					end else begin
						ref_cnt <= ref_cnt + 16'h0001;
					end
				end
				BHD_REF_DONE: begin
					ref_state <= BHD_REF_DONE;
				end
				default: begin
					ref_state <= BHD_REF_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-phase undervoltage and switch outputs

	logic [2:0] uv, next_uv;
	logic [2:0] hs_q, ls_q;
	logic refresh_on;

	assign refresh_on = (ref_state == BHD_REF_ACTIVE) && !next_pwm;

	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_phase
			always_comb begin
				next_uv[p] = uv[p];
				if (sup_s[p] < `BHD_UV_DETECT) begin
					next_uv[p] = 1'b1;
				end else if (sup_s[p] >=
					`BHD_UV_DETECT + `BHD_UV_HYSTERESIS) begin
					next_uv[p] = 1'b0;
				end
			end

			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					uv[p] <= 1'b1;
				end else begin
					uv[p] <= next_uv[p];
				end
			end

			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					hs_q[p] <= 1'b0;
				end else if (!run || !hs_cmd[p] || next_uv[p] || !next_pwm) begin
					hs_q[p] <= 1'b0;
				end else if (turn_on) begin
					hs_q[p] <= 1'b1;
				end
			end

			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					ls_q[p] <= 1'b0;
				end else begin
					ls_q[p] <= run && (ls_cmd[p] ||
						(hs_cmd[p] && refresh_on));
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Revolution pulse

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			revolution_pulse_out <= 1'b0;
		end else if (sel_eff) begin
			revolution_pulse_out <= bhd_three_pulse(hall_code);
		end else begin
			revolution_pulse_out <= hall_code[2];
		end
	end

	assign {high_side_a, high_side_b, high_side_c} = hs_q;
	assign {low_side_a, low_side_b, low_side_c} = ls_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	logic [5:0] dec_q;
	assign dec_q = bhd_decode(hall_q);

	a_hall_compare: assert property (@(posedge ref_clk) disable iff (!nrst)
		hall_q[2] == $past(a_pos_s > a_neg_s))
		else $error("hall level not from comparison");

	a_decode_low: assert property (@(posedge ref_clk) disable iff (!nrst)
		run_q |-> ((ls_q & dec_q[2:0]) == dec_q[2:0]))
		else $error("decoded low side not on");

	a_invalid_off: assert property (@(posedge ref_clk) disable iff (!nrst)
		(hall_q == 3'b000 || hall_q == 3'b111) |-> (hs_q == 3'b000 &&
		ls_q == 3'b000))
		else $error("switch on for invalid hall code");

	a_fg_three: assert property (@(posedge ref_clk) disable iff (!nrst)
		sel_q |-> revolution_pulse_out == bhd_three_pulse(hall_q))
		else $error("three pulse output wrong");

	a_fg_one: assert property (@(posedge ref_clk) disable iff (!nrst)
		!sel_q |-> revolution_pulse_out == hall_q[2])
		else $error("one pulse output wrong");

	a_fg_open: assert property (@(posedge ref_clk) disable iff (!nrst)
		$past(open_s) |-> revolution_pulse_out == bhd_three_pulse(hall_q))
		else $error("open select not three pulse");

	a_pwm_high_only: assert property (@(posedge ref_clk) disable iff (!nrst)
		(hs_q != 3'b000) |-> (pwm_q && (hs_q & ~dec_q[5:3]) == 3'b000))
		else $error("high side on outside pwm on time");

	a_low_not_pwm: assert property (@(posedge ref_clk) disable iff (!nrst)
		((ls_q & ~dec_q[2:0]) != 3'b000) |-> !pwm_q)
		else $error("extra low side during pwm on");

	a_speed_off: assert property (@(posedge ref_clk) disable iff (!nrst)
		!run_q |-> (hs_q == 3'b000 && ls_q == 3'b000))
		else $error("switch on below off threshold");

	a_turn_on_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
		((hs_q & ~$past(hs_q)) != 3'b000) |-> turn_q)
		else $error("high side on without edge");

	a_uv_high_off: assert property (@(posedge ref_clk) disable iff (!nrst)
		(uv != 3'b000) |-> ((hs_q & uv) == 3'b000))
		else $error("high side on under undervoltage");

	a_refresh_len: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ref_state == BHD_REF_ACTIVE) |-> (ref_cnt <= refresh_len))
		else $error("refresh longer than one fifth");

	a_pwm_compare: assert property (@(posedge ref_clk) disable iff (!nrst)
		pwm_q == $past(speed_s > carrier))
		else $error("pwm state not from carrier compare");

endmodule

`default_nettype wire

// File: bhd_hall_model.sv
// Hall sensor and speed controller model for the commutation bench
`default_nettype none

module bhd_hall_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Commands from the bench
	input wire logic [2:0] code,
	input wire logic [7:0] speed_cmd,
	// Comparator terminals, index 2 is phase a
	output logic [7:0] pos [3],
	output logic [7:0] neg [3],
	// Speed reference
	output logic [7:0] speed_reference
);
	timeunit 1ns;
	timeprecision 100ps;
	integer seed = 32'h87a6;
	logic [7:0] n;

	initial begin
		pos = '{8'h00, 8'h00, 8'h00};
		neg = '{8'h00, 8'h00, 8'h00};
		speed_reference = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Speed held off in reset, full duty never commanded
	always @(posedge ref_clk) begin
		if (!nrst) begin
			speed_reference <= 8'h00;
		end else if (speed_cmd == 8'hff) begin
			speed_reference <= 8'hfe;
		end else begin
			speed_reference <= speed_cmd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fresh terminal levels every cycle, equal levels read as low
	always @(posedge ref_clk) begin
		for (int i = 0; i < 3; i++) begin
			n = 8'($random(seed)) & 8'h7f;
			neg[i] <= n;
			if (code[i]) begin
				pos[i] <= n + 8'h01 + (8'($random(seed)) & 8'h3f);
			end else begin
				pos[i] <= n & 8'($random(seed));
			end
		end
	end
endmodule

`default_nettype wire

// File: bhd_commutation_test.sv
// Self-checking bench for the hall commutation decoder
`default_nettype none

module bhd_commutation_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] code = 3'b101;
	logic [7:0] speed_cmd = 8'h80;
	logic sel = 1'b1;
	logic sel_open = 1'b0;
	logic [3:0] cap = 4'h1;
	logic [3:0] res = 4'h1;
	logic [7:0] sup [3] = '{8'hff, 8'hff, 8'hff};
	logic [7:0] hp [3];
	logic [7:0] hn [3];
	logic [7:0] spd;
	logic [2:0] hs;
	logic [2:0] ls;
	logic fg;
	logic [5:0] e;
	logic [2:0] valid [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	int hon, lon, bad, act, div, s;
	integer seed = 32'h87a6;

	always #50 ref_clk = ~ref_clk;

	bhd_hall_model partner (.ref_clk(ref_clk), .nrst(nrst), .code(code),
		.speed_cmd(speed_cmd), .pos(hp), .neg(hn), .speed_reference(spd));

	bhd_commutation dut (.ref_clk(ref_clk), .nrst(nrst),
		.hall_a_pos(hp[2]), .hall_a_neg(hn[2]),
		.hall_b_pos(hp[1]), .hall_b_neg(hn[1]),
		.hall_c_pos(hp[0]), .hall_c_neg(hn[0]),
		.pulse_count_select(sel), .pulse_count_select_open(sel_open),
		.speed_reference(spd), .carrier_capacitor_pin(cap),
		.carrier_resistor_pin(res), .hs_supply_a(sup[2]),
		.hs_supply_b(sup[1]), .hs_supply_c(sup[0]),
		.high_side_a(hs[2]), .high_side_b(hs[1]), .high_side_c(hs[0]),
		.low_side_a(ls[2]), .low_side_b(ls[1]), .low_side_c(ls[0]),
		.revolution_pulse_out(fg));

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (num_errors == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask

	// Accept a count within three of the figure expected
	function automatic logic [15:0] near(input int seen, input int exp);
		return 16'((seen - exp <= 3 && exp - seen <= 3) ? exp : seen);
	endfunction

	function automatic logic [5:0] decode(input logic [2:0] c);
		case (c)
			3'b101: return 6'b010_100;
			3'b100: return 6'b001_100;
			3'b110: return 6'b001_010;
			3'b010: return 6'b100_010;
			3'b011: return 6'b100_001;
			3'b001: return 6'b010_001;
			default: return 6'h00;
		endcase
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Count high and low side on time of the commanded phase
	task automatic measure(input int n);
		hon = 0;
		lon = 0;
		bad = 0;
		act = 0;
		e = decode(code);
		repeat (n) begin
			step(1);
			hon += int'((hs & e[5:3]) != 0);
			lon += int'((ls & e[5:3]) != 0);
			act += int'({hs, ls} != 0);
			bad += int'((hs & ~e[5:3]) != 0 || (ls & e[2:0]) != e[2:0]
				|| (ls & ~e[2:0] & ~e[5:3]) != 0);
		end
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		step(4);
		nrst = 1'b1;
		step(4);
		for (int m = 0; m < 32; m++) begin
			sel = m[3];
			sel_open = m[4];
			code = m[2:0];
			step(6);
			e = decode(code);
			check(16'(fg), 16'((sel | sel_open) ? (code == 3'h5 || code == 3'h6
				|| code == 3'h3) : code[2]));
			check(16'(ls & e[2:0]), 16'(e[2:0]));
			check(16'(hs & ~e[5:3]), 16'h0);
			check(16'(ls & ~e[2:0] & ~e[5:3]), 16'h0);
		end
		code = 3'b101;
		speed_cmd = 8'h1f;
		step(8);
		measure(600);
		check(16'(act), 16'h0);
		for (int k = 0; k < 6; k++) begin
			speed_cmd = (k == 0) ? 8'h20 : (k == 1) ? 8'hfe :
				8'h21 + 8'($random(seed)) % 8'hdd;
			code = valid[k];
			cap = 4'($random(seed)) % 4'h3;
			res = 4'h1 + 4'($random(seed)) % 4'h2;
			div = ((cap == 0) ? 1 : int'(cap)) * int'(res);
			s = int'(speed_cmd);
			step(6 + 510 * div);
			measure(510 * div);
			check(near(hon, (2 * s - 1) * div), 16'((2 * s - 1) * div));
			s = (511 - 2 * s < 102) ? 511 - 2 * s : 102;
			check(near(lon, s * div), 16'(s * div));
			check(16'(bad), 16'h0);
		end
		code = 3'b010;
		speed_cmd = 8'h80;
		cap = 4'h1;
		res = 4'h1;
		for (int u = 0; u < 3; u++) begin
			sup[2] = (u == 0) ? 8'h2f : (u == 1) ? 8'h3f : 8'h40;
			step(520);
			measure(510);
			check(near(hon, (u == 2) ? 255 : 0), (u == 2) ? 16'd255 : 16'h0);
		end
		complete_run();
	end
endmodule

`default_nettype wire
